// *** power_irq_format_control.sv ***
// power mode, interrupt and output format registers of a motion sensor
// assumes the serial port logic gives one-cycle reg_wr and reg_rd pulses
// and the detectors give one-cycle event pulses on core_clk
`timescale 1ns/1ps
`include "motion_ctl_map.svh"
module power_irq_format_control #(
    parameter int SLEEP_BASE_CYCLES = `SLEEP_BASE_CYCLES
) (
    input wire logic core_clk, // 20 MHz core clock
    input wire logic rst, // async reset, active high
    input wire logic [5:0] reg_addr, // register offset
    input wire logic reg_wr, // write pulse
    input wire logic reg_rd, // read pulse
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
    input wire logic act_enabled, // activity function has an axis on
    input wire logic inact_enabled, // inactivity function has an axis on
    input wire logic act_detected, // activity event pulse
    input wire logic inact_detected, // inactivity event pulse
    input wire logic one_knock_evt, // single knock event pulse
    input wire logic two_knock_evt, // double knock event pulse
    input wire logic drop_evt, // drop event pulse
    input wire logic watermark_evt, // fifo watermark event pulse
    input wire logic overrun_evt, // fifo overrun event pulse
    input wire logic odr_tick, // output data rate tick
    input wire logic [15:0] x_raw, // x sample, finest scale
    input wire logic [15:0] y_raw, // y sample, finest scale
    input wire logic [15:0] z_raw, // z sample, finest scale
    output logic measuring, // measurement mode
    output logic sleeping, // sleep in effect
    output logic asleep_flag, // auto sleep state
    output logic act_run, // activity detector may run
    output logic inact_run, // inactivity detector may run
    output logic sample_strobe, // axis data registers refresh
    output logic fifo_write_allow, // samples may enter the fifo
    output logic force_check, // apply test force
    output logic three_wire, // 3-wire serial mode
    output logic irq_pin_a, // interrupt pin a
    output logic irq_pin_b // interrupt pin b
);
    motion_ctl_pkg::power_t power_mode_control_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] interrupt_routing_reg;
    motion_ctl_pkg::irq_bits_t interrupt_status_reg;
    motion_ctl_pkg::irq_bits_t status_next;
    motion_ctl_pkg::irq_bits_t status_set;
    motion_ctl_pkg::format_t output_format_control_reg;
    motion_ctl_pkg::link_state_t link_reg;
    motion_ctl_pkg::link_state_t link_next;
    motion_ctl_pkg::doze_state_t doze_reg;
    motion_ctl_pkg::doze_state_t doze_next;
    logic [15:0] x_axis_output_reg;
    logic [15:0] y_axis_output_reg;
    logic [15:0] z_axis_output_reg;
    logic [15:0] x_shaped;
    logic [15:0] y_shaped;
    logic [15:0] z_shaped;
    logic [7:0] rdata_next;
    logic [7:0] status_clr;
    logic [7:0] pending;
    logic linked;
    logic auto_on;
    logic sleep_tick;
    logic irq_a_next;
    logic irq_b_next;

    function automatic logic is_data_addr(input logic [5:0] a);
        return (a >= `OFS_DATA_FIRST) && (a <= `OFS_DATA_LAST);
    endfunction
    assign measuring = power_mode_control_reg.measure;
    assign linked = power_mode_control_reg.link && act_enabled
        && inact_enabled;
    // auto_doze only counts while link is set
    assign auto_on = power_mode_control_reg.link
        && power_mode_control_reg.auto_doze;
    assign sleeping = power_mode_control_reg.sleep
        || (auto_on && doze_reg == motion_ctl_pkg::DOZING);
    assign asleep_flag = (doze_reg == motion_ctl_pkg::DOZING);
    assign act_run = measuring
        && (!linked || link_reg == motion_ctl_pkg::SEEK_ACT);
    // sleep leaves only the activity function alive
    assign inact_run = measuring && !sleeping
        && (!linked || link_reg == motion_ctl_pkg::SEEK_INACT);
    assign sample_strobe = measuring
        && (sleeping ? sleep_tick : odr_tick);
    assign fifo_write_allow = measuring && !sleeping && odr_tick;
    assign force_check = output_format_control_reg.force_check;
    assign three_wire = output_format_control_reg.three_wire;

    sleep_rate_tick #(
        .BASE_CYCLES(SLEEP_BASE_CYCLES)
    ) u_sleep_tick (
        .core_clk(core_clk),
        .rst(rst),
        .run(measuring && sleeping),
        .sleep_rate_sel(power_mode_control_reg.sleep_rate_sel),
        .tick(sleep_tick)
    );
    axis_formatter u_fmt_x (
        .raw(x_raw),
        .fmt(output_format_control_reg),
        .shaped(x_shaped)
    );
    axis_formatter u_fmt_y (
        .raw(y_raw),
        .fmt(output_format_control_reg),
        .shaped(y_shaped)
    );
    axis_formatter u_fmt_z (
        .raw(z_raw),
        .fmt(output_format_control_reg),
        .shaped(z_shaped)
    );
    // control registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            power_mode_control_reg <= `RST_POWER_MODE;
            interrupt_enable_reg <= `RST_IRQ_ENABLE;
            interrupt_routing_reg <= `RST_IRQ_ROUTING;
            output_format_control_reg <= `RST_OUT_FORMAT;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `OFS_POWER_MODE:
                    power_mode_control_reg <= reg_wdata & `POWER_WMASK;
                `OFS_IRQ_ENABLE:
                    interrupt_enable_reg <= reg_wdata;
                `OFS_IRQ_ROUTING:
                    interrupt_routing_reg <= reg_wdata;
                `OFS_OUT_FORMAT:
                    output_format_control_reg <= reg_wdata & `FORMAT_WMASK;
                default:
                    ;
            endcase
        end
    end

    // link sequencing between activity and inactivity
    always_comb
    begin
        link_next = link_reg;
        case (link_reg)
            motion_ctl_pkg::SEEK_INACT:
                if (linked && measuring && inact_detected)
                    link_next = motion_ctl_pkg::SEEK_ACT;
            motion_ctl_pkg::SEEK_ACT:
                if (act_detected)
                    link_next = motion_ctl_pkg::SEEK_INACT;
            default:
                link_next = motion_ctl_pkg::SEEK_INACT;
        endcase
        // unlinked restarts the sequence at inactivity
        if (!linked || !measuring)
            link_next = motion_ctl_pkg::SEEK_INACT;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            link_reg <= motion_ctl_pkg::SEEK_INACT;
        else
            link_reg <= link_next;
    end

    // automatic sleep; the state freezes while auto_doze is off
    always_comb
    begin
        doze_next = doze_reg;
        case (doze_reg)
            motion_ctl_pkg::AWAKE:
                if (auto_on && inact_enabled && inact_run && inact_detected)
                    doze_next = motion_ctl_pkg::DOZING;
            motion_ctl_pkg::DOZING:
                if (auto_on && act_enabled && act_run && act_detected)
                    doze_next = motion_ctl_pkg::AWAKE;
            default:
                doze_next = motion_ctl_pkg::AWAKE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            doze_reg <= motion_ctl_pkg::AWAKE;
        else
            doze_reg <= doze_next;
    end

    // axis data follows the sample strobe, in sleep too
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            x_axis_output_reg <= 16'h0000;
            y_axis_output_reg <= 16'h0000;
            z_axis_output_reg <= 16'h0000;
        end
        else if (sample_strobe)
        begin
            x_axis_output_reg <= x_shaped;
            y_axis_output_reg <= y_shaped;
            z_axis_output_reg <= z_shaped;
        end
    end

    // event sources; sleep stops all but activity, watermark and overrun
    always_comb
    begin
        status_set.sample_available = sample_strobe && !sleeping;
        status_set.one_knock = one_knock_evt && measuring && !sleeping;
        status_set.two_knock = two_knock_evt && measuring && !sleeping;
        status_set.activity = act_detected && act_run;
        status_set.inactivity = inact_detected && inact_run;
        status_set.drop_detect = drop_evt && measuring && !sleeping;
        status_set.watermark = watermark_evt;
        status_set.overrun = overrun_evt;
    end

    // a set in the clearing cycle wins over the clear
    always_comb
    begin
        status_clr = 8'h00;
        if (reg_rd && is_data_addr(reg_addr))
            status_clr = status_clr | `STATUS_DATA_CLR;
        if (reg_rd && reg_addr == `OFS_IRQ_STATUS)
            status_clr = status_clr | `STATUS_READ_CLR;
        status_next = (interrupt_status_reg & ~status_clr)
            | status_set;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            interrupt_status_reg <= 8'h00;
        else
            interrupt_status_reg <= status_next;
    end

    // pins: enabled events, routed, ORed, then polarity
    always_comb
    begin
        pending = interrupt_status_reg & interrupt_enable_reg;
        irq_a_next = (|(pending & ~interrupt_routing_reg))
            ^ output_format_control_reg.irq_polarity_low;
        irq_b_next = (|(pending & interrupt_routing_reg))
            ^ output_format_control_reg.irq_polarity_low;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_pin_a <= 1'b0;
            irq_pin_b <= 1'b0;
        end
        else
        begin
            irq_pin_a <= irq_a_next;
            irq_pin_b <= irq_b_next;
        end
    end

    // read mux; offsets owned elsewhere answer zero here
    always_comb
    begin
        case (reg_addr)
            `OFS_POWER_MODE: rdata_next = power_mode_control_reg;
            `OFS_IRQ_ENABLE: rdata_next = interrupt_enable_reg;
            `OFS_IRQ_ROUTING: rdata_next = interrupt_routing_reg;
            `OFS_IRQ_STATUS: rdata_next = interrupt_status_reg;
            `OFS_OUT_FORMAT: rdata_next = output_format_control_reg;
            6'h32: rdata_next = x_axis_output_reg[7:0];
            6'h33: rdata_next = x_axis_output_reg[15:8];
            6'h34: rdata_next = y_axis_output_reg[7:0];
            6'h35: rdata_next = y_axis_output_reg[15:8];
            6'h36: rdata_next = z_axis_output_reg[7:0];
            6'h37: rdata_next = z_axis_output_reg[15:8];
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_next;
    end

    chk_link_holds_act: assert property (
        @(posedge core_clk) disable iff (rst)
        (linked && link_reg == motion_ctl_pkg::SEEK_INACT) |-> !act_run)
        else $error("activity ran before inactivity in linked mode");
    chk_unlinked_both_run: assert property (
        @(posedge core_clk) disable iff (rst)
        (measuring && !power_mode_control_reg.link && !sleeping)
        |-> (act_run && inact_run))
        else $error("unlinked detectors not both running");
    chk_auto_doze_entry: assert property (
        @(posedge core_clk) disable iff (rst)
        (auto_on && !sleeping && inact_enabled && inact_run
        && inact_detected && !reg_wr) |=> sleeping)
        else $error("auto sleep not entered on inactivity");
    chk_doze_ignored: assert property (
        @(posedge core_clk) disable iff (rst)
        !power_mode_control_reg.link
        |-> (sleeping == power_mode_control_reg.sleep))
        else $error("auto_doze acted without link");
    chk_standby_at_start: assert property (
        @(posedge core_clk) $fell(rst) |-> !measuring && !sample_strobe)
        else $error("not in standby after reset");
    chk_sleep_no_fifo: assert property (
        @(posedge core_clk) disable iff (rst)
        sleeping |-> !fifo_write_allow && !inact_run)
        else $error("fifo write or inactivity during sleep");
    chk_sleep_refresh: assert property (
        @(posedge core_clk) disable iff (rst)
        (sleeping && measuring && sleep_tick) |-> sample_strobe
        ##1 (x_axis_output_reg == $past(x_shaped)))
        else $error("axis data not refreshed in sleep");
    chk_irq_blocked: assert property (
        @(posedge core_clk) disable iff (rst)
        ((interrupt_status_reg & interrupt_enable_reg) == 8'h00)
        |=> (irq_pin_a == $past(output_format_control_reg.irq_polarity_low))
        && (irq_pin_b == $past(output_format_control_reg.irq_polarity_low)))
        else $error("interrupt pin active with nothing enabled");
    chk_wm_always_sets: assert property (
        @(posedge core_clk) disable iff (rst)
        watermark_evt |=> interrupt_status_reg.watermark)
        else $error("watermark status did not set");
    chk_status_read_clr: assert property (
        @(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == `OFS_IRQ_STATUS && !act_detected
        && !inact_detected && !one_knock_evt && !two_knock_evt
        && !drop_evt)
        |=> ((interrupt_status_reg & `STATUS_READ_CLR) == 8'h00))
        else $error("status read did not clear event bits");
    chk_data_read_keeps: assert property (
        @(posedge core_clk) disable iff (rst)
        (interrupt_status_reg.overrun && !(reg_rd
        && is_data_addr(reg_addr))) |=> interrupt_status_reg.overrun)
        else $error("overrun cleared without a data read");

endmodule // power_irq_format_control

// *** motion_ctl_map.svh ***
// register offsets, write and clear masks, reset values and timing counts
// for the power, interrupt and output format control block
`ifndef MOTION_CTL_MAP_SVH
`define MOTION_CTL_MAP_SVH

`define OFS_POWER_MODE 6'h2d
`define OFS_IRQ_ENABLE 6'h2e
`define OFS_IRQ_ROUTING 6'h2f
`define OFS_IRQ_STATUS 6'h30
`define OFS_OUT_FORMAT 6'h31
`define OFS_DATA_FIRST 6'h32
`define OFS_DATA_LAST 6'h37

`define RST_POWER_MODE 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_IRQ_ROUTING 8'h00
`define RST_OUT_FORMAT 8'h00

`define POWER_WMASK 8'h3f
`define FORMAT_WMASK 8'hef
`define STATUS_DATA_CLR 8'h83
`define STATUS_READ_CLR 8'h7c

`define CLK_HZ 20000000
`define SLEEP_MAX_HZ 8
`define SLEEP_BASE_CYCLES (`CLK_HZ / `SLEEP_MAX_HZ)

`endif

// *** motion_ctl_pkg.sv ***
// types shared by the power, interrupt and output format control files
// assumes motion_ctl_map.svh carries all numeric constants
package motion_ctl_pkg;

    typedef struct packed {
        logic [1:0] zero;
        logic link;
        logic auto_doze;
        logic measure;
        logic sleep;
        logic [1:0] sleep_rate_sel;
    } power_t;

    typedef struct packed {
        logic force_check;
        logic three_wire;
        logic irq_polarity_low;
        logic zero;
        logic max_resolution;
        logic justify;
        logic [1:0] range;
    } format_t;

    typedef struct packed {
        logic sample_available;
        logic one_knock;
        logic two_knock;
        logic activity;
        logic inactivity;
        logic drop_detect;
        logic watermark;
        logic overrun;
    } irq_bits_t;

    typedef enum {SEEK_INACT, SEEK_ACT} link_state_t;
    typedef enum {AWAKE, DOZING} doze_state_t;

endpackage

// *** sleep_rate_tick.sv ***
// sleep-mode reading tick: 8, 4, 2 or 1 Hz from the core clock
// assumes run is low outside sleep so the phase restarts on entry
`timescale 1ns/1ps
module sleep_rate_tick #(
    parameter int BASE_CYCLES = 2500000
) (
    input wire logic core_clk, // core clock
    input wire logic rst, // async reset, active high
    input wire logic run, // count while high
    input wire logic [1:0] sleep_rate_sel, // 00 8 Hz .. 11 1 Hz
    output logic tick // one-cycle pulse
);
    logic [21:0] base_reg;
    logic [2:0] div_reg;
    logic [2:0] mask;
    logic base_wrap;

    assign base_wrap = (base_reg == 22'(BASE_CYCLES - 1));
    // each step of the field halves the rate
    always_comb
    begin
        case (sleep_rate_sel)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            base_reg <= 22'h000000;
            div_reg <= 3'h0;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            base_reg <= 22'h000000;
            div_reg <= 3'h0;
            tick <= 1'b0;
        end
        else
        begin
            base_reg <= base_wrap ? 22'h000000 : base_reg + 22'h000001;
            if (base_wrap)
                div_reg <= div_reg + 3'h1;
            tick <= base_wrap && ((div_reg & mask) == mask);
        end
    end
endmodule // sleep_rate_tick

// *** axis_formatter.sv ***
// one axis of output formatting: range, resolution, clipping, justify
// assumes raw is signed at the finest scale, combinational result
`timescale 1ns/1ps
module axis_formatter (
    input wire logic [15:0] raw, // signed sample, finest scale
    input wire motion_ctl_pkg::format_t fmt, // format control fields
    output logic [15:0] shaped // value for the output data bytes
);
    logic [1:0] shift;
    logic [4:0] width;
    logic signed [16:0] v;
    logic signed [16:0] lim;

    always_comb
    begin
        // fixed mode scales by range, full mode widens with it
        shift = fmt.max_resolution ? 2'h0 : fmt.range;
        width = fmt.max_resolution ? 5'd10 + {3'h0, fmt.range} : 5'd10;
        v = $signed({raw[15], raw}) >>> shift;
        lim = (17'sd1 <<< (width - 5'd1)) - 17'sd1;
        // the widest range is left to wrap, all others clip
        if (fmt.range != 2'h3)
        begin
            if (v > lim)
                v = lim;
            else if (v < -lim - 17'sd1)
                v = -lim - 17'sd1;
        end
        if (fmt.justify)
            shaped = v[15:0] << (5'd16 - width);
        else
            shaped = v[15:0];
    end
endmodule // axis_formatter

// *** event_pulser.sv ***
// detector and fifo event source standing in for the far side
// assumes the bench sets requests just after a rising edge
`timescale 1ns/1ps
module event_pulser (
    input wire logic core_clk, // core clock
    input wire logic [7:0] req, // one bit per event, status order
    output motion_ctl_pkg::irq_bits_t evt // one-cycle event pulses
);
    logic [7:0] req_reg;
    // edge detect so a request held too long cannot fire twice
    always_ff @(posedge core_clk)
    begin
        req_reg <= req;
        evt <= req & ~req_reg;
    end
endmodule // event_pulser

// *** tb.sv ***
// register and event tests of the power, interrupt and format block
// assumes the map header and package are compiled first
`timescale 1ns/1ps
`include "motion_ctl_map.svh"
module tb;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic odr_tick = 1'b0, act_en = 1'b0, inact_en = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, req = 8'h00, reg_rdata, v;
    logic measuring, sleeping, asleep_flag, act_run, inact_run;
    logic sample_strobe, fifo_write_allow, force_check, three_wire;
    logic irq_pin_a, irq_pin_b;
    logic [15:0] x_raw = 16'h0123;
    motion_ctl_pkg::irq_bits_t evt;
    int err_total = 0, cmp_count = 0;
    power_irq_format_control #(.SLEEP_BASE_CYCLES(20))
    power_irq_format_control_i (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .act_enabled(act_en), .inact_enabled(inact_en),
        .act_detected(evt.activity), .inact_detected(evt.inactivity),
        .one_knock_evt(evt.one_knock), .two_knock_evt(evt.two_knock),
        .drop_evt(evt.drop_detect), .watermark_evt(evt.watermark),
        .overrun_evt(evt.overrun), .odr_tick(odr_tick),
        .x_raw(x_raw), .y_raw(16'hfe01), .z_raw(16'h0040),
        .measuring(measuring), .sleeping(sleeping),
        .asleep_flag(asleep_flag), .act_run(act_run),
        .inact_run(inact_run), .sample_strobe(sample_strobe),
        .fifo_write_allow(fifo_write_allow), .force_check(force_check),
        .three_wire(three_wire), .irq_pin_a(irq_pin_a),
        .irq_pin_b(irq_pin_b));
    event_pulser event_pulser_i (.core_clk(core_clk), .req(req),
        .evt(evt));
    initial forever #25 core_clk = ~core_clk;
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic xfer(input logic [5:0] a, input logic [7:0] d,
                        input logic w);
        @(posedge core_clk) #5;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = ~w;
        @(posedge core_clk) #5;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // one more edge so registered pins see the change
        @(posedge core_clk) #5;
        v = reg_rdata;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        xfer(a, d, 1'b1);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        xfer(a, 8'h00, 1'b0);
        chk8(v, e);
    endtask
    task automatic fire(input logic [7:0] b);
        @(posedge core_clk) #5;
        req = b;
        @(posedge core_clk) #5;
        req = 8'h00;
        repeat (3) @(posedge core_clk);
        #5;
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        final_report();
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        #5;
        rst = 1'b0;
        rdc(`OFS_POWER_MODE, `RST_POWER_MODE);
        rdc(`OFS_IRQ_ENABLE, `RST_IRQ_ENABLE);
        rdc(`OFS_IRQ_ROUTING, `RST_IRQ_ROUTING);
        rdc(`OFS_OUT_FORMAT, `RST_OUT_FORMAT);
        chk1(measuring, 1'b0);
        $display("reset values done");
        wr(`OFS_OUT_FORMAT, 8'hff);
        rdc(`OFS_OUT_FORMAT, 8'hef);
        chk1(force_check, 1'b1);
        chk1(three_wire, 1'b1);
        chk1(irq_pin_a, 1'b1);
        wr(`OFS_OUT_FORMAT, 8'h00);
        chk1(force_check, 1'b0);
        chk1(three_wire, 1'b0);
        chk1(irq_pin_a, 1'b0);
        rdc(6'h3f, 8'h00);
        $display("format done");
        wr(`OFS_IRQ_ENABLE, 8'h02);
        fire(8'h02);
        chk1(irq_pin_a, 1'b1);
        chk1(irq_pin_b, 1'b0);
        rdc(`OFS_IRQ_STATUS, 8'h02);
        rdc(`OFS_IRQ_STATUS, 8'h02);
        rdc(`OFS_DATA_FIRST, 8'h00);
        rdc(`OFS_IRQ_STATUS, 8'h00);
        chk1(irq_pin_a, 1'b0);
        wr(`OFS_IRQ_ROUTING, 8'h02);
        fire(8'h02);
        chk1(irq_pin_b, 1'b1);
        chk1(irq_pin_a, 1'b0);
        wr(`OFS_IRQ_ENABLE, 8'h00);
        chk1(irq_pin_b, 1'b0);
        rdc(`OFS_DATA_LAST, 8'h00);
        fire(8'h01);
        rdc(`OFS_IRQ_STATUS, 8'h01);
        chk1(irq_pin_b, 1'b0);
        rdc(`OFS_DATA_FIRST, 8'h00);
        $display("enable and routing done");
        wr(`OFS_POWER_MODE, 8'h08);
        chk1(measuring, 1'b1);
        wr(`OFS_IRQ_ENABLE, 8'h04);
        wr(`OFS_IRQ_ROUTING, 8'h00);
        fire(8'h04);
        chk1(irq_pin_a, 1'b1);
        rdc(`OFS_IRQ_STATUS, 8'h04);
        chk1(irq_pin_a, 1'b0);
        rdc(`OFS_IRQ_STATUS, 8'h00);
        $display("clear on read done");
        act_en = 1'b1;
        inact_en = 1'b1;
        wr(`OFS_POWER_MODE, 8'h18);
        chk1(act_run, 1'b1);
        chk1(inact_run, 1'b1);
        fire(8'h08);
        chk1(sleeping, 1'b0);
        wr(`OFS_POWER_MODE, 8'h28);
        chk1(act_run, 1'b0);
        fire(8'h08);
        chk1(act_run, 1'b1);
        chk1(inact_run, 1'b0);
        chk1(asleep_flag, 1'b0);
        fire(8'h10);
        wr(`OFS_POWER_MODE, 8'h38);
        fire(8'h08);
        chk1(sleeping, 1'b1);
        chk1(asleep_flag, 1'b1);
        fire(8'h10);
        chk1(sleeping, 1'b0);
        wr(`OFS_POWER_MODE, 8'h00);
        $display("link and auto sleep done");
        wr(`OFS_POWER_MODE, 8'h0c);
        chk1(sleeping, 1'b1);
        odr_tick = 1'b1;
        #1;
        chk1(fifo_write_allow, 1'b0);
        @(posedge core_clk) #5;
        odr_tick = 1'b0;
        // 8 Hz sleep rate is one tick per 20 cycles in this bench
        repeat (25) @(posedge core_clk);
        rdc(`OFS_DATA_FIRST, 8'h23);
        rdc(6'h35, 8'hfe);
        rdc(`OFS_IRQ_STATUS, 8'h18);
        wr(`OFS_POWER_MODE, 8'h00);
        wr(`OFS_POWER_MODE, 8'h08);
        x_raw = 16'h0300;
        odr_tick = 1'b1;
        #1;
        chk1(fifo_write_allow, 1'b1);
        @(posedge core_clk) #5;
        odr_tick = 1'b0;
        rdc(`OFS_IRQ_STATUS, 8'h80);
        rdc(`OFS_DATA_FIRST, 8'hff);
        rdc(6'h33, 8'h01);
        rdc(`OFS_IRQ_STATUS, 8'h00);
        wr(`OFS_OUT_FORMAT, 8'h04);
        odr_tick = 1'b1;
        @(posedge core_clk) #5;
        odr_tick = 1'b0;
        rdc(6'h33, 8'h7f);
        rdc(`OFS_DATA_FIRST, 8'hc0);
        $display("sleep done");
        final_report();
    end
endmodule // tb
